// file: core/mpas_pkg.sv
// microprogram address sequencer: shared widths, codes, carriers
// assumes one clock domain; all users write mpas_pkg::name
package mpas_pkg;

  localparam int ADDR_W = 10;
  localparam int STACK_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int FC_W = 3;
  localparam int SYNC_STAGES = 3;

  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONES = 10'h3FF;
  localparam logic [ADDR_W-1:0] STEP1 = 10'h001;
  localparam logic [ADDR_W-1:0] STEP2 = 10'h002;
  localparam logic [PTR_W-1:0] PTR_RST = 2'h0;
  localparam logic [PTR_W-1:0] PTR_STEP = 2'h1;
  localparam logic EN_N_RST = 1'h1;

  // sequencing function codes as seen on function_select
  typedef enum logic [FC_W-1:0] {
    FC_SKIP_IF_TRUE = 3'h0,
    FC_INCREMENT = 3'h1,
    FC_LOOP_BACK_IF_TRUE = 3'h2,
    FC_RETURN = 3'h3,
    FC_CALL_IF_TRUE = 3'h4,
    FC_SAVE_LOOP_TOP = 3'h5,
    FC_JUMP_IF_TRUE = 3'h6,
    FC_ZERO_ADDRESS = 3'h7
  } mpas_fc_t;

  // next-address multiplexer sources, one-hot
  typedef enum logic [4:0] {
    SRC_BRANCH = 5'h01,
    SRC_INC1 = 5'h02,
    SRC_INC2 = 5'h04,
    SRC_STACK = 5'h08,
    SRC_ZERO = 5'h10
  } mpas_src_t;

  typedef struct packed {
    mpas_fc_t fc;
    logic test;
    logic [ADDR_W-1:0] branch;
  } mpas_ctl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } mpas_core_t;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] chain;
    logic lvl;
  } mpas_sync_t;

endpackage : mpas_pkg

// file: core/mpas_pin_sync.sv
// three-flop synchroniser for one level pin
// the level only moves once the second and third stages agree
`timescale 1ns/1ns
module mpas_pin_sync #(
  parameter logic RESET_VAL = 1'h1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic pin_in,
  output logic lvl_out
);

  mpas_pkg::mpas_sync_t st_q;
  mpas_pkg::mpas_sync_t st_d;

  // =========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.chain = {st_q.chain[mpas_pkg::SYNC_STAGES-2:0], pin_in};
    // stage 0 feeds only stage 1; the agreement looks at stages 1 and 2
    if (st_q.chain[1] == st_q.chain[2]) begin
      st_d.lvl = st_q.chain[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= {{mpas_pkg::SYNC_STAGES{RESET_VAL}}, RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign lvl_out = st_q.lvl;

endmodule : mpas_pin_sync

// file: core/mpas_return_stack.sv
// four-entry lifo of return addresses with a wrapping pointer
// assumes push and pop never come in the same cycle
`timescale 1ns/1ns
module mpas_return_stack #(
  parameter int DEPTH = mpas_pkg::STACK_DEPTH,
  parameter int W = mpas_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] top_data,
  output logic [mpas_pkg::PTR_W-1:0] ptr
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] entry;
    logic [mpas_pkg::PTR_W-1:0] ptr;
  } mpas_stack_t;

  mpas_stack_t st_q;
  mpas_stack_t st_d;
  logic [mpas_pkg::PTR_W-1:0] top_idx;

  // pointer names the next free slot, so the newest entry sits one below;
  // on an empty stack this wraps to the fourth slot, whose content is stale
  assign top_idx = st_q.ptr - mpas_pkg::PTR_STEP;
  assign top_data = st_q.entry[top_idx];
  assign ptr = st_q.ptr;

  // =========================================================
  // next state
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < DEPTH; i++) begin
      // a push on a full stack lands on the oldest slot
      if (push && (st_q.ptr == i[mpas_pkg::PTR_W-1:0])) begin
        st_d.entry[i] = wr_data;
      end
    end
    if (push) begin
      st_d.ptr = st_q.ptr + mpas_pkg::PTR_STEP;
    end else if (pop) begin
      st_d.ptr = st_q.ptr - mpas_pkg::PTR_STEP;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : mpas_return_stack

// file: core/mpas_sequencer.sv
// microprogram address sequencer top: address register, next-address
// multiplexer, return stack and three-state address output control
// assumes function_select, test_cond and branch_target_in come from the
// microprogram memory and status logic on ref_clk, settled before the edge
`timescale 1ns/1ns
module mpas_sequencer #(
  parameter int ADDR_W = mpas_pkg::ADDR_W,
  parameter int STACK_DEPTH = mpas_pkg::STACK_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [mpas_pkg::FC_W-1:0] function_select,
  input wire logic test_cond,
  input wire logic [ADDR_W-1:0] branch_target_in,
  input wire logic out_en_n,
  output logic [ADDR_W-1:0] next_address_out,
  output logic next_address_oe,
  output logic [mpas_pkg::PTR_W-1:0] stack_ptr
);

  // =========================================================
  // decode helpers
  // push and pop are each needed only for the stack; the checks decode ctl.fc again

  function automatic mpas_pkg::mpas_src_t pick_source(
    input mpas_pkg::mpas_fc_t fc,
    input logic test
  );
    mpas_pkg::mpas_src_t src;
    src = mpas_pkg::SRC_INC1;
    case (fc)
      mpas_pkg::FC_SKIP_IF_TRUE: begin
        src = test ? mpas_pkg::SRC_INC2 : mpas_pkg::SRC_INC1;
      end
      mpas_pkg::FC_INCREMENT: begin
        src = mpas_pkg::SRC_INC1;
      end
      mpas_pkg::FC_LOOP_BACK_IF_TRUE: begin
        src = test ? mpas_pkg::SRC_STACK : mpas_pkg::SRC_INC1;
      end
      mpas_pkg::FC_RETURN: begin
        src = mpas_pkg::SRC_STACK;
      end
      mpas_pkg::FC_CALL_IF_TRUE: begin
        src = test ? mpas_pkg::SRC_BRANCH : mpas_pkg::SRC_INC1;
      end
      mpas_pkg::FC_SAVE_LOOP_TOP: begin
        src = mpas_pkg::SRC_INC1;
      end
      mpas_pkg::FC_JUMP_IF_TRUE: begin
        src = test ? mpas_pkg::SRC_BRANCH : mpas_pkg::SRC_INC1;
      end
      mpas_pkg::FC_ZERO_ADDRESS: begin
        src = mpas_pkg::SRC_ZERO;
      end
      default: begin
        src = mpas_pkg::SRC_INC1;
      end
    endcase
    return src;
  endfunction : pick_source

  function automatic logic does_push(
    input mpas_pkg::mpas_fc_t fc,
    input logic test
  );
    return (fc == mpas_pkg::FC_CALL_IF_TRUE && test) ||
           (fc == mpas_pkg::FC_SAVE_LOOP_TOP);
  endfunction : does_push

  // loop-back pops whatever the test says; only the address differs
  function automatic logic does_pop(
    input mpas_pkg::mpas_fc_t fc
  );
    return (fc == mpas_pkg::FC_LOOP_BACK_IF_TRUE) ||
           (fc == mpas_pkg::FC_RETURN);
  endfunction : does_pop

  // =========================================================
  // inputs and state

  mpas_pkg::mpas_ctl_t ctl;
  mpas_pkg::mpas_core_t st_q;
  mpas_pkg::mpas_core_t st_d;
  mpas_pkg::mpas_src_t src;
  logic push;
  logic pop;
  logic [ADDR_W-1:0] push_data;
  logic [ADDR_W-1:0] top_data;
  logic [ADDR_W-1:0] addr_inc1;
  logic [ADDR_W-1:0] addr_inc2;
  logic en_n_lvl;

  assign ctl.fc = mpas_pkg::mpas_fc_t'(function_select);
  assign ctl.test = test_cond;
  assign ctl.branch = branch_target_in;

  // =========================================================
  // next-address arithmetic
  // sums are cut to the register width so the counter wraps

  assign addr_inc1 = ADDR_W'(st_q.addr + mpas_pkg::STEP1);
  assign addr_inc2 = ADDR_W'(st_q.addr + mpas_pkg::STEP2);

  // =========================================================
  // function decode

  always_comb begin
    src = pick_source(ctl.fc, ctl.test);
    push = does_push(ctl.fc, ctl.test);
    pop = does_pop(ctl.fc);
    // a call saves the return point, a loop top saves itself
    if (ctl.fc == mpas_pkg::FC_SAVE_LOOP_TOP) begin
      push_data = st_q.addr;
    end else begin
      push_data = addr_inc1;
    end
  end

  // =========================================================
  // address register

  always_comb begin
    st_d = st_q;
    case (src)
      mpas_pkg::SRC_BRANCH: begin
        st_d.addr = ctl.branch;
      end
      mpas_pkg::SRC_INC1: begin
        st_d.addr = addr_inc1;
      end
      mpas_pkg::SRC_INC2: begin
        st_d.addr = addr_inc2;
      end
      mpas_pkg::SRC_STACK: begin
        st_d.addr = top_data;
      end
      mpas_pkg::SRC_ZERO: begin
        st_d.addr = mpas_pkg::ADDR_ZERO;
      end
      default: begin
        st_d.addr = addr_inc1;
      end
    endcase
  end

  // the reset pin only gives simulation a known start; in the field the
  // zero-address code does the initialising
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{addr: mpas_pkg::ADDR_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // =========================================================
  // return stack

  mpas_return_stack #(
    .DEPTH(STACK_DEPTH),
    .W(ADDR_W)
  ) u_stack (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .push(push),
    .pop(pop),
    .wr_data(push_data),
    .top_data(top_data),
    .ptr(stack_ptr)
  );

  // =========================================================
  // output drivers
  // the enable gates only the drivers; nothing above reads it

  mpas_pin_sync #(
    .RESET_VAL(mpas_pkg::EN_N_RST)
  ) u_en_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(out_en_n),
    .lvl_out(en_n_lvl)
  );

  assign next_address_out = st_q.addr;
  assign next_address_oe = !en_n_lvl;

  // =========================================================
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence call_taken_s;
    ctl.fc == mpas_pkg::FC_CALL_IF_TRUE && ctl.test;
  endsequence

  sequence return_s;
    ctl.fc == mpas_pkg::FC_RETURN;
  endsequence

  sequence save_top_s;
    ctl.fc == mpas_pkg::FC_SAVE_LOOP_TOP;
  endsequence

  sequence loop_taken_s;
    ctl.fc == mpas_pkg::FC_LOOP_BACK_IF_TRUE && ctl.test;
  endsequence

  zero_address_a: assert property (
    ctl.fc == mpas_pkg::FC_ZERO_ADDRESS |=>
      next_address_out == mpas_pkg::ADDR_ZERO && $stable(stack_ptr)
  ) else $error("zero-address code did not clear the address");

  plain_step_a: assert property (
    ctl.fc == mpas_pkg::FC_INCREMENT |=>
      next_address_out == ADDR_W'($past(next_address_out) + mpas_pkg::STEP1) &&
      $stable(stack_ptr)
  ) else $error("increment code did not step by one");

  addr_wrap_a: assert property (
    ctl.fc == mpas_pkg::FC_INCREMENT && next_address_out == mpas_pkg::ADDR_ONES |=>
      next_address_out == mpas_pkg::ADDR_ZERO
  ) else $error("address did not wrap to zero");

  skip_step_a: assert property (
    ctl.fc == mpas_pkg::FC_SKIP_IF_TRUE |=>
      next_address_out == ADDR_W'($past(next_address_out) +
        ($past(ctl.test) ? mpas_pkg::STEP2 : mpas_pkg::STEP1)) && $stable(stack_ptr)
  ) else $error("skip code took the wrong step");

  jump_taken_a: assert property (
    ctl.fc == mpas_pkg::FC_JUMP_IF_TRUE && ctl.test |=>
      next_address_out == $past(ctl.branch) && $stable(stack_ptr)
  ) else $error("jump did not load the branch inputs");

  call_return_a: assert property (
    call_taken_s ##1 return_s |=>
      next_address_out == ADDR_W'($past(next_address_out, 2) + mpas_pkg::STEP1) &&
      stack_ptr == $past(stack_ptr, 2)
  ) else $error("return did not resume after the call");

  call_push_a: assert property (
    call_taken_s |=>
      next_address_out == $past(ctl.branch) &&
      stack_ptr == $past(stack_ptr) + mpas_pkg::PTR_STEP
  ) else $error("call did not branch and push");

  return_pop_a: assert property (
    return_s |=>
      next_address_out == $past(top_data) &&
      stack_ptr == $past(stack_ptr) - mpas_pkg::PTR_STEP
  ) else $error("return did not pop the stack");

  loop_repeat_a: assert property (
    save_top_s ##1 loop_taken_s |=>
      next_address_out == $past(next_address_out, 2) &&
      stack_ptr == $past(stack_ptr, 2)
  ) else $error("loop did not go back to its top");

  loop_exit_a: assert property (
    ctl.fc == mpas_pkg::FC_LOOP_BACK_IF_TRUE && !ctl.test |=>
      next_address_out == ADDR_W'($past(next_address_out) + mpas_pkg::STEP1) &&
      stack_ptr == $past(stack_ptr) - mpas_pkg::PTR_STEP
  ) else $error("loop exit did not drop the entry");

  output_float_a: assert property (
    out_en_n [*4] |=> !next_address_oe
  ) else $error("drivers stayed on while enable pin high");

  // the first low sample must come after reset release: the edge that lifts rstn
  // still resets the synchroniser and so loses that sample
  output_drive_a: assert property (
    (rstn && !out_en_n) ##1 !out_en_n [*3] |=> next_address_oe
  ) else $error("drivers stayed off while enable pin low");

endmodule : mpas_sequencer

// file: bench/mpas_ucode_mem.sv
// stand-in for the microprogram memory and the status selection logic
// assumes the bench calls issue() just after a rising ref_clk edge
`timescale 1ns/1ns
module mpas_ucode_mem (
  input wire logic [mpas_pkg::ADDR_W-1:0] next_address_out,
  input wire logic next_address_oe,
  output logic [mpas_pkg::FC_W-1:0] function_select,
  output logic test_cond,
  output logic [mpas_pkg::ADDR_W-1:0] branch_target_in,
  output wire [mpas_pkg::ADDR_W-1:0] addr_bus
);
  // =====================================================
  // memory outputs
  // disabled memory outputs float to the pull-up level, which is the clear code
  initial begin
    function_select = 3'h7;
    test_cond = 1'b0;
    branch_target_in = 10'h000;
  end

  // code and branch field come from the word, test from the status picker
  task automatic issue(input logic [2:0] fc, input logic t, input logic [9:0] br);
    function_select <= fc;
    test_cond <= t;
    branch_target_in <= br;
  endtask : issue

  // =====================================================
  // shared address bus
  assign addr_bus = next_address_oe ? next_address_out : {mpas_pkg::ADDR_W{1'bz}};
endmodule : mpas_ucode_mem

// file: bench/microprogram_address_sequencer_tb.sv
// self-checking bench for the microprogram address sequencer
// assumes the design asserts its own rules; this bench keeps a reference copy
`timescale 1ns/1ns
module microprogram_address_sequencer_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic out_en_n = 1'b0;
  logic [2:0] function_select;
  logic test_cond;
  logic [9:0] branch_target_in;
  logic [9:0] next_address_out;
  logic next_address_oe;
  logic [1:0] stack_ptr;
  wire [9:0] addr_bus;
  logic [9:0] ea = 10'h000;
  logic [1:0] ep = 2'h0;
  logic [9:0] stk [4] = '{10'h000, 10'h000, 10'h000, 10'h000};
  logic oe_seen = 1'b0;
  int err_count = 0;
  int samples_checked = 0;

  always #4 ref_clk = ~ref_clk;

  mpas_sequencer dut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .function_select(function_select),
    .test_cond(test_cond),
    .branch_target_in(branch_target_in),
    .out_en_n(out_en_n),
    .next_address_out(next_address_out),
    .next_address_oe(next_address_oe),
    .stack_ptr(stack_ptr)
  );

  mpas_ucode_mem mem (
    .next_address_out(next_address_out),
    .next_address_oe(next_address_oe),
    .function_select(function_select),
    .test_cond(test_cond),
    .branch_target_in(branch_target_in),
    .addr_bus(addr_bus)
  );

  // =====================================================
  // helpers
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // one sequencing cycle: entered and left at a rising edge; the code issued here is taken
  // at the next edge, so the falling edge in between still shows the previous code's result
  task automatic step(input logic [2:0] fc, input logic t, input logic [9:0] br);
    mem.issue(fc, t, br);
    @(negedge ref_clk);
    check(next_address_out, ea, "address");
    check({8'h00, stack_ptr}, {8'h00, ep}, "pointer");
    check(addr_bus, (next_address_oe === 1'b1) ? ea : {10{1'bz}}, "bus");
    oe_seen = next_address_oe;
    // the reference moves on only after the check, in step with the taking edge
    case (fc)
      3'h0: ea = t ? ea + 10'h002 : ea + 10'h001;
      3'h1: ea = ea + 10'h001;
      3'h2: begin
        ep = ep - 2'h1;
        ea = t ? stk[ep] : ea + 10'h001;
      end
      3'h3: begin
        ep = ep - 2'h1;
        ea = stk[ep];
      end
      3'h4: begin
        if (t) begin
          stk[ep] = ea + 10'h001;
          ep = ep + 2'h1;
        end
        ea = t ? br : ea + 10'h001;
      end
      3'h5: begin
        stk[ep] = ea;
        ep = ep + 2'h1;
        ea = ea + 10'h001;
      end
      3'h6: ea = t ? br : ea + 10'h001;
      default: ea = 10'h000;
    endcase
    @(posedge ref_clk);
  endtask : step

  // =====================================================
  // scenarios
  task automatic sc_jump_wrap;
    step(3'h6, 1'b1, 10'h3FE);
    step(3'h6, 1'b0, 10'h155);
    step(3'h1, 1'b0, 10'h2AA);
    step(3'h1, 1'b1, 10'h000);
  endtask : sc_jump_wrap

  task automatic sc_skip;
    step(3'h6, 1'b1, 10'h3FE);
    step(3'h0, 1'b1, 10'h155);
    step(3'h0, 1'b0, 10'h155);
  endtask : sc_skip

  task automatic sc_call_return;
    step(3'h6, 1'b1, 10'h100);
    step(3'h4, 1'b0, 10'h2AA);
    step(3'h4, 1'b1, 10'h2AA);
    step(3'h4, 1'b1, 10'h155);
    step(3'h3, 1'b0, 10'h000);
    step(3'h3, 1'b1, 10'h000);
  endtask : sc_call_return

  task automatic sc_loop;
    step(3'h5, 1'b0, 10'h0F0);
    step(3'h1, 1'b0, 10'h000);
    step(3'h2, 1'b1, 10'h000);
    step(3'h5, 1'b1, 10'h000);
    step(3'h2, 1'b0, 10'h3C3);
  endtask : sc_loop

  // five pushes lose the oldest; the fifth pop reads a slot again
  task automatic sc_overflow;
    repeat (5) step(3'h5, 1'b0, 10'h000);
    repeat (5) step(3'h3, 1'b0, 10'h000);
  endtask : sc_overflow

  task automatic sc_clear;
    step(3'h6, 1'b1, 10'h2C3);
    step(3'h5, 1'b0, 10'h000);
    step(3'h7, 1'b0, 10'h155);
    step(3'h6, 1'b1, 10'h0A5);
    step(3'h7, 1'b1, 10'h3FF);
  endtask : sc_clear

  // outputs float while disabled yet the sequence keeps running
  task automatic sc_enable;
    int n;
    out_en_n <= 1'b1;
    repeat (6) step(3'h1, 1'b0, 10'h000);
    check({9'h000, oe_seen}, 10'h000, "disable");
    out_en_n <= 1'b0;
    n = 0;
    while (oe_seen !== 1'b1 && n < 8) begin
      step(3'h5, 1'b0, 10'h000);
      n++;
    end
    if (n == 8) begin
      err_count++;
      $display("CHECK FAILED at %0t: outputs never enabled", $time);
      stop_test;
    end
    step(3'h2, 1'b1, 10'h000);
  endtask : sc_enable

  // =====================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    step(3'h7, 1'b0, 10'h000);
    sc_jump_wrap();
    sc_skip();
    sc_call_return();
    sc_loop();
    sc_overflow();
    sc_clear();
    sc_enable();
    // one more cycle so the last scenario's final code is judged too
    step(3'h1, 1'b0, 10'h000);
    stop_test();
  end
endmodule : microprogram_address_sequencer_tb
